// file: design/elir_defs.svh
// Register offsets, field positions, reset values and timing counts of the log info block
`ifndef ELIR_DEFS_SVH
`define ELIR_DEFS_SVH

`define ELIR_ADDR_W          8
`define ELIR_OFS_CTRL        8'h00
`define ELIR_OFS_POLICY      8'h04
`define ELIR_OFS_SET_LO      8'h08
`define ELIR_OFS_SET_HI      8'h0c
`define ELIR_OFS_NOW_LO      8'h10
`define ELIR_OFS_NOW_HI      8'h14
`define ELIR_OFS_COUNT       8'h18
`define ELIR_OFS_STATUS      8'h1c

`define ELIR_CTRL_RETAIN     0
`define ELIR_CTRL_UTC_LSB    8
`define ELIR_POL_POLICY_LSB  0
`define ELIR_POL_QUANT_LSB   8
`define ELIR_POL_WEAR_LSB    16
`define ELIR_SET_HUND_LSB    8
`define ELIR_SET_GO          31
`define ELIR_STAT_FILL_LSB   0
`define ELIR_STAT_HEALTH_LSB 8
`define ELIR_STAT_BUSY       16

`define ELIR_RST_CTRL        32'h0000ff01
`define ELIR_RST_POLICY      32'h00ff0100

`define ELIR_UNSPEC          8'hff
`define ELIR_PCT_MAX         8'h64
`define ELIR_HUND_MAX        7'h63
`define ELIR_HUND_HALF       7'h32
`define ELIR_RESULT_OK       8'h00
`define ELIR_RESP_BYTES      23

`define ELIR_CLOCK_NS        8
`define ELIR_HUNDREDTH_NS    10000000
`define ELIR_HUNDREDTH_CYC   (`ELIR_HUNDREDTH_NS / `ELIR_CLOCK_NS)

`endif

// file: design/elir_pkg.sv
// Types shared by the log info block
package elir_pkg;

	typedef enum logic [1:0] {
		ELIR_FILL_AND_STOP = 2'b00,
		ELIR_FIRST_IN_OUT  = 2'b01,
		ELIR_CLEAR_ON_AGE  = 2'b10
	} elir_policy_type;

	typedef enum logic [0:0] {
		ELIR_IDLE = 1'b0,
		ELIR_SEND = 1'b1
	} elir_state_type;

	// Log clock time in seconds and hundredths
	typedef struct packed {
		logic [39:0] seconds;
		logic [6:0]  hundredths;
	} elir_time_type;

	// Storage-side events, one-cycle pulses on the system clock
	typedef struct packed {
		logic        entry_added;
		logic        entry_changed;
		logic        entries_deleted;
		logic [31:0] delete_total;
		logic        log_cleared;
		logic        stamp_lost;
	} elir_event_type;

	// Response byte stream towards the message interface
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} elir_byte_type;

endpackage

// file: design/elir_log_clock.sv
// Log clock: free-running seconds and hundredths, loadable by the clock-setting command
`timescale 1ns/10ps
`include "elir_defs.svh"

module elir_log_clock #(
	parameter int          SUB_SECOND = 1,
	parameter int unsigned TICKS      = `ELIR_HUNDREDTH_CYC
) (
	// System
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	// Clock-setting command
	input  wire logic                   set_go,
	input  wire elir_pkg::elir_time_type set_time,
	// Time and the shift that a set applies
	output elir_pkg::elir_time_type      now,
	output logic signed [40:0]           diff_sec,
	output logic signed [7:0]            diff_hund
);
	import elir_pkg::*;

	logic [31:0]   tick;
	elir_time_type load;
	logic          tick_wrap;
	logic          hund_wrap;
	logic          round_up;

	// Without sub-second resolution a set time rounds to the nearest second
	assign round_up       = (SUB_SECOND == 0) && (set_time.hundredths >= `ELIR_HUND_HALF);
	assign load.seconds    = set_time.seconds + {39'h0, round_up};
	assign load.hundredths = (SUB_SECOND == 0) ? 7'h00 :
		((set_time.hundredths > `ELIR_HUND_MAX) ? `ELIR_HUND_MAX : set_time.hundredths);
	assign diff_sec  = $signed({1'b0, load.seconds}) - $signed({1'b0, now.seconds});
	assign diff_hund = $signed({1'b0, load.hundredths}) - $signed({1'b0, now.hundredths});
	assign tick_wrap = (tick == TICKS - 1);
	assign hund_wrap = (now.hundredths == `ELIR_HUND_MAX);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 32'h0;
			now  <= '0;
		end else if (set_go) begin
			tick <= 32'h0;
			now  <= load;
		end else begin
			tick <= tick_wrap ? 32'h0 : tick + 32'h1;
			if (tick_wrap) begin
				now.hundredths <= hund_wrap ? 7'h00 : now.hundredths + 7'h1;
				now.seconds    <= now.seconds + {39'h0, hund_wrap};
			end
		end
	end

endmodule // elir_log_clock

// file: design/elir_stamp.sv
// One stored timestamp: capture, invalidate and shift with the log clock
`timescale 1ns/10ps
`include "elir_defs.svh"

module elir_stamp (
	// System
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	// Control
	input  wire logic                    capture,
	input  wire logic                    invalidate,
	input  wire logic                    adjust,
	input  wire elir_pkg::elir_time_type now,
	input  wire logic signed [40:0]      diff_sec,
	input  wire logic signed [7:0]       diff_hund,
	// Stored time; zero seconds means unspecified
	output elir_pkg::elir_time_type      stamp
);
	import elir_pkg::*;

	logic signed [8:0] sum_hund;
	logic              borrow;
	logic              carry;
	elir_time_type     shifted;

	assign sum_hund = $signed({2'b00, stamp.hundredths}) + $signed({diff_hund[7], diff_hund});
	assign borrow   = sum_hund < 0;
	assign carry    = sum_hund > $signed({2'b00, `ELIR_HUND_MAX});
	assign shifted.seconds = stamp.seconds + diff_sec[39:0]
		- {39'h0, borrow} + {39'h0, carry};
	assign shifted.hundredths = borrow ? 7'(sum_hund + 9'sd100) :
		(carry ? 7'(sum_hund - 9'sd100) : sum_hund[6:0]);

	// A capture outranks a shift, and an unspecified stamp stays unspecified
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			stamp <= '0;
		else if (capture)
			stamp <= now;
		else if (invalidate)
			stamp <= '0;
		else if (adjust && stamp.seconds != 40'h0)
			stamp <= shifted;
	end

endmodule // elir_stamp

// file: design/elir_top.sv
// Event-log information responder: counters, timestamps, APB registers, byte serialiser
//
// What this block does
// - Keeps and reports the number of entries now in the log as a 32-bit count.
// - Reports storage fill 0..100 stepped by the fill quantum, 0xff when unknown.
// - Reports medium wear as set by software, above 100 past rated life, 0xff unknown.
// - Stamps the insertion time with the log clock on every add or change.
// - Shifts the insertion stamp by the same amount when the log clock is set.
// - On a clear keeps the insertion stamp or makes it unspecified, as configured.
// - Stamps the removal time on every deletion and on every clear.
// - Shifts the removal stamp by the same amount when the log clock is set.
// - The removal stamp is unspecified only before first use or after a loss.
// - Each stamp carries a signed half-hour offset from universal time, 0xff unknown.
// - Each stamp carries 40-bit seconds since 1970, zero meaning unspecified.
// - Each stamp carries hundredths 0..99, or 0xff when unspecified or when only seconds are resolved.
// - The tail follows the result code, the log health and the purge policy.
// - The log clock resolves a second or finer and rounds a set time to that.
`timescale 1ns/10ps
`include "elir_defs.svh"

module elir_top #(
	parameter int          SUB_SECOND = 1,
	parameter int unsigned TICKS      = `ELIR_HUNDREDTH_CYC
) (
	// System
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`ELIR_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Storage side
	input  wire elir_pkg::elir_event_type log_event,
	input  wire logic [7:0]               fill_raw,
	input  wire logic [7:0]               log_health_state,
	// Message side
	input  wire logic                     log_info_query,
	input  wire logic                     resp_ready,
	output elir_pkg::elir_byte_type       resp
);
	import elir_pkg::*;

	localparam int NB = `ELIR_RESP_BYTES;

	////////////////////////////////////////////////////////////////////////////
	// Register bus

	logic [31:0]     ctrl;
	logic [31:0]     policy;
	logic [31:0]     set_lo;
	logic [31:0]     set_hi;
	logic [31:0]     log_entry_total;
	elir_state_type  state;

	wire             access  = psel && penable;
	wire             wr      = access && pwrite;
	wire             hit_ctrl   = paddr == `ELIR_OFS_CTRL;
	wire             hit_policy = paddr == `ELIR_OFS_POLICY;
	wire             hit_set_lo = paddr == `ELIR_OFS_SET_LO;
	wire             hit_set_hi = paddr == `ELIR_OFS_SET_HI;
	wire             hit_now_lo = paddr == `ELIR_OFS_NOW_LO;
	wire             hit_now_hi = paddr == `ELIR_OFS_NOW_HI;
	wire             hit_count  = paddr == `ELIR_OFS_COUNT;
	wire             hit_status = paddr == `ELIR_OFS_STATUS;
	wire             mapped  = hit_ctrl | hit_policy | hit_set_lo | hit_set_hi
		| hit_now_lo | hit_now_hi | hit_count | hit_status;
	wire             set_go  = wr && hit_set_hi && pwdata[`ELIR_SET_GO];

	wire             retain_insert = ctrl[`ELIR_CTRL_RETAIN];
	wire [7:0]       utc_offset    = ctrl[`ELIR_CTRL_UTC_LSB +: 8];
	wire [7:0]       purge_policy  = {6'h0, policy[`ELIR_POL_POLICY_LSB +: 2]};
	wire [7:0]       fill_quantum  = policy[`ELIR_POL_QUANT_LSB +: 8];
	wire [7:0]       medium_wear_percent = policy[`ELIR_POL_WEAR_LSB +: 8];

	elir_time_type   now;
	elir_time_type   set_time;
	elir_time_type   last_insert_time;
	elir_time_type   last_removal_time;
	logic signed [40:0] diff_sec;
	logic signed [7:0]  diff_hund;
	logic [7:0]      storage_fill_percent;
	logic [31:0]     read_mux;

	// Seconds 39:32 and hundredths come from the write that issues the command
	assign set_time.seconds    = {pwdata[7:0], set_lo};
	assign set_time.hundredths = pwdata[`ELIR_SET_HUND_LSB +: 7];

	always_comb begin
		read_mux = 32'h0;
		if (hit_ctrl)
			read_mux = ctrl;
		if (hit_policy)
			read_mux = policy;
		if (hit_set_lo)
			read_mux = set_lo;
		if (hit_set_hi)
			read_mux = {16'h0, set_hi[15:0]};
		if (hit_now_lo)
			read_mux = now.seconds[31:0];
		if (hit_now_hi)
			read_mux = {17'h0, now.hundredths, now.seconds[39:32]};
		if (hit_count)
			read_mux = log_entry_total;
		if (hit_status)
			read_mux = {15'h0, state == ELIR_SEND, log_health_state, storage_fill_percent};
	end

	// Zero wait states; unmapped addresses answer with an error and read zero
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata  = read_mux;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl   <= `ELIR_RST_CTRL;
			policy <= `ELIR_RST_POLICY;
			set_lo <= 32'h0;
			set_hi <= 32'h0;
		end else if (wr) begin
			if (hit_ctrl)
				ctrl <= {16'h0, pwdata[15:8], 7'h0, pwdata[0]};
			if (hit_policy)
				policy <= {8'h0, pwdata[23:8], 6'h0, pwdata[1:0]};
			if (hit_set_lo)
				set_lo <= pwdata;
			if (hit_set_hi)
				set_hi <= {16'h0, 1'b0, pwdata[14:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Entry count and fill

	logic [31:0] next_total;
	logic [7:0]  fill_step;

	always_comb begin
		next_total = log_entry_total;
		if (log_event.entries_deleted)
			next_total = (log_event.delete_total > next_total) ? 32'h0
				: next_total - log_event.delete_total;
		if (log_event.entry_added)
			next_total = next_total + 32'h1;
		// An add in the same cycle as a clear counts as the first entry after it
		if (log_event.log_cleared)
			next_total = {31'h0, log_event.entry_added};
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			log_entry_total <= 32'h0;
		else
			log_entry_total <= next_total;
	end

	// A zero quantum is treated as a step of one
	assign fill_step = (fill_quantum == 8'h0) ? fill_raw : fill_raw - (fill_raw % fill_quantum);
	assign storage_fill_percent = (fill_raw > `ELIR_PCT_MAX) ? `ELIR_UNSPEC : fill_step;

	////////////////////////////////////////////////////////////////////////////
	// Log clock and stamps

	elir_log_clock #(
		.SUB_SECOND (SUB_SECOND),
		.TICKS      (TICKS)
	) u_clock (
		.clock     (clock),
		.rst_n     (rst_n),
		.set_go    (set_go),
		.set_time  (set_time),
		.now       (now),
		.diff_sec  (diff_sec),
		.diff_hund (diff_hund)
	);

	wire insert_capture = log_event.entry_added || log_event.entry_changed;
	wire insert_drop    = (log_event.log_cleared && !retain_insert) || log_event.stamp_lost;
	wire removal_capture = log_event.entries_deleted || log_event.log_cleared;

	elir_stamp u_insert (
		.clock      (clock),
		.rst_n      (rst_n),
		.capture    (insert_capture),
		.invalidate (insert_drop),
		.adjust     (set_go),
		.now        (now),
		.diff_sec   (diff_sec),
		.diff_hund  (diff_hund),
		.stamp      (last_insert_time)
	);

	elir_stamp u_removal (
		.clock      (clock),
		.rst_n      (rst_n),
		.capture    (removal_capture),
		.invalidate (log_event.stamp_lost),
		.adjust     (set_go),
		.now        (now),
		.diff_sec   (diff_sec),
		.diff_hund  (diff_hund),
		.stamp      (last_removal_time)
	);

	////////////////////////////////////////////////////////////////////////////
	// Response image and serialiser

	wire        ins_unspec = last_insert_time.seconds == 40'h0;
	wire        rem_unspec = last_removal_time.seconds == 40'h0;
	wire [7:0]  ins_off  = ins_unspec ? `ELIR_UNSPEC : utc_offset;
	wire [7:0]  rem_off  = rem_unspec ? `ELIR_UNSPEC : utc_offset;
	wire [7:0]  ins_hund = (ins_unspec || SUB_SECOND == 0) ? `ELIR_UNSPEC
		: {1'b0, last_insert_time.hundredths};
	wire [7:0]  rem_hund = (rem_unspec || SUB_SECOND == 0) ? `ELIR_UNSPEC
		: {1'b0, last_removal_time.hundredths};

	// Byte 0 sits in the low bits, so packed fields come out LSB first
	wire [8*NB-1:0] image = {
		rem_hund, last_removal_time.seconds, rem_off,
		ins_hund, last_insert_time.seconds, ins_off,
		medium_wear_percent, storage_fill_percent, log_entry_total,
		purge_policy, log_health_state, `ELIR_RESULT_OK
	};

	logic [8*NB-1:0] snap;
	logic [4:0]      index;
	wire             take     = resp.valid && resp_ready;
	wire             at_end   = index == 5'(NB - 1);
	wire [4:0]       next_index = index + 5'h1;

	// Snapshot at the query so the answer is coherent even while the log moves
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ELIR_IDLE;
			snap  <= '0;
			index <= 5'h0;
			resp  <= '0;
		end else begin
			unique case (state)
				ELIR_IDLE: begin
					if (log_info_query) begin
						state      <= ELIR_SEND;
						snap       <= image;
						index      <= 5'h0;
						resp.valid <= 1'b1;
						resp.data  <= image[7:0];
						resp.last  <= 1'b0;
					end
				end
				ELIR_SEND: begin
					if (take && at_end) begin
						state      <= ELIR_IDLE;
						resp.valid <= 1'b0;
						resp.last  <= 1'b0;
					end else if (take) begin
						index     <= next_index;
						resp.data <= snap[next_index*8 +: 8];
						resp.last <= next_index == 5'(NB - 1);
					end
				end
			endcase
		end
	end

endmodule // elir_top

// file: sim/elir_assertions.sv
// Checker of the log info responder stream at the top ports
`timescale 1ns/10ps
module elir_assertions import elir_pkg::*; (
	// System
	input wire logic                    clock,
	input wire logic                    rst_n,
	// Message side
	input wire logic [7:0]              log_health_state,
	input wire logic                    log_info_query,
	input wire logic                    resp_ready,
	input wire elir_pkg::elir_byte_type resp
);
	logic [4:0] idx;
	logic [7:0] hsnap;

	// Index of the byte now offered; health is snapshot at the query edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) idx <= '0;
		else if (!resp.valid) idx <= '0;
		else if (resp_ready) idx <= idx + 5'h01;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) hsnap <= '0;
		else if (log_info_query && !resp.valid) hsnap <= log_health_state;
	end

	////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	chk_answer_one: assert property (log_info_query && !resp.valid
		|=> resp.valid && idx == 5'h00 && resp.data == 8'h00) else $error("bad start");
	chk_byte_hold: assert property (resp.valid && !resp_ready |=> $stable(resp))
		else $error("byte moved while stalled");
	chk_stream_on: assert property (resp.valid && resp_ready && !resp.last |=> resp.valid)
		else $error("stream broke early");
	chk_stream_end: assert property (resp.valid && resp_ready && resp.last
		|=> !resp.valid && !resp.last) else $error("stream did not end");
	chk_last_index: assert property (resp.valid |-> resp.last == (idx == 5'h16))
		else $error("last flag on wrong byte");
	chk_health_copy: assert property (resp.valid && idx == 5'h01 |-> resp.data == hsnap)
		else $error("health byte wrong");
	chk_fill_legal: assert property (resp.valid && idx == 5'h07
		|-> resp.data <= 8'h64 || resp.data == 8'hff) else $error("fill out of range");
	chk_hund_legal: assert property (resp.valid && (idx == 5'h0f || idx == 5'h16)
		|-> resp.data <= 8'h63 || resp.data == 8'hff) else $error("hundredths out of range");
endmodule // elir_assertions

bind elir_top elir_assertions i_elir_assertions (.clock, .rst_n, .log_health_state,
	.log_info_query, .resp_ready, .resp);

// file: sim/elir_requester.sv
// Remote requester model: raises queries and takes the response bytes
`timescale 1ns/10ps
module elir_requester import elir_pkg::*; (
	// System
	input wire logic                    clock,
	// Message side
	input wire elir_pkg::elir_byte_type resp,
	output logic                        query,
	output logic                        ready
);
	logic [7:0] got [23];
	int         n;
	logic       last_seen;

	initial begin
		query = 1'b0;
		ready = 1'b0;
	end

	// A slow requester drops ready every other cycle, so each byte after the first must wait
	task automatic ask(input logic slow);
		n = 0;
		last_seen = 1'b0;
		@(posedge clock);
		query <= 1'b1;
		ready <= 1'b1;
		@(posedge clock);
		query <= 1'b0;
		for (int k = 0; k < 200 && n < 23; k++) begin
			@(posedge clock);
			if (resp.valid && ready) begin
				got[n] = resp.data;
				last_seen = resp.last;
				n++;
			end
			ready <= (n < 23) && (!slow || !ready);
		end
	endtask
endmodule // elir_requester

// file: sim/tb_top.sv
// Self-checking bench of the log info responder
`timescale 1ns/10ps
module tb_top;
	import elir_pkg::*;
	localparam logic [39:0] SEC = 40'h0123456789;
	logic           clock, rst_n, psel, penable, pwrite, pready, pslverr, query, ready, err;
	logic [7:0]     paddr, fill_raw, health;
	logic [31:0]    pwdata, prdata, rd;
	elir_event_type ev;
	elir_byte_type  resp;
	int             mismatches, check_count;

	elir_top #(.TICKS(4)) i_elir_top (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .log_event(ev), .fill_raw(fill_raw),
		.log_health_state(health), .log_info_query(query), .resp_ready(ready), .resp(resp));
	elir_requester i_elir_requester (.clock(clock), .resp(resp), .query(query), .ready(ready));

	always #4 clock = ~clock;

	////////////////////////////////////////
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clock);
			if (pready) break;
		end
		if (k == 20) begin
			mismatches++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic set_clk(input logic [39:0] s, input logic [6:0] h);
		apb(1'b1, 8'h08, s[31:0]);
		apb(1'b1, 8'h0c, {1'b1, 16'h0000, h, s[39:32]});
	endtask

	task automatic pulse(input elir_event_type e);
		@(posedge clock);
		ev <= e;
		@(posedge clock);
		ev <= '0;
	endtask

	task automatic ask(input logic slow);
		i_elir_requester.ask(slow);
		chk(40'(i_elir_requester.n), 40'd23);
		chk(40'(i_elir_requester.last_seen), 40'h1);
	endtask

	// Little-endian field out of the captured response
	function automatic logic [39:0] fld(input int lo, input int nb);
		fld = '0;
		for (int i = nb - 1; i >= 0; i--) fld = {fld[31:0], i_elir_requester.got[lo + i]};
	endfunction

	task automatic stamp(input int lo, input logic [7:0] off, input logic [39:0] s);
		chk(fld(lo, 1), 40'(off));
		chk(fld(lo + 1, 5), s);
		if (s == '0) chk(fld(lo + 6, 1), 40'hff);
		else chk(40'(fld(lo + 6, 1) <= 40'h63), 40'h1);
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		apb(1'b0, 8'h00, '0);
		chk(40'(rd), 40'h0000ff01);
		apb(1'b0, 8'h04, '0);
		chk(40'(rd), 40'h00ff0100);
		apb(1'b1, 8'h20, 32'h12345678);
		chk(40'(err), 40'h1);
		ask(1'b0);
		chk(fld(3, 4), 40'h0);
		stamp(9, 8'hff, '0);
		stamp(16, 8'hff, '0);
	endtask

	task automatic t_report();
		elir_event_type e;
		apb(1'b1, 8'h00, 32'h00000401);
		apb(1'b1, 8'h04, 32'h007b0a02);
		set_clk(SEC, 7'h00);
		fill_raw <= 8'h39;
		health <= 8'h03;
		e = '0;
		e.entry_added = 1'b1;
		repeat (3) pulse(e);
		e = '0;
		e.entries_deleted = 1'b1;
		e.delete_total = 32'h1;
		pulse(e);
		ask(1'b1);
		chk(fld(1, 2), 40'h0203);
		chk(fld(3, 4), 40'h2);
		chk(fld(7, 1), 40'h32);
		chk(fld(8, 1), 40'h7b);
		stamp(9, 8'h04, SEC);
		stamp(16, 8'h04, SEC);
		apb(1'b0, 8'h18, '0);
		chk(40'(rd), 40'h2);
		apb(1'b0, 8'h1c, '0);
		chk(40'(rd), 40'h00000332);
	endtask

	// Stamps must follow a set that moves the log clock 1000 s ahead
	task automatic t_adjust();
		set_clk(SEC + 40'h3e8, 7'h32);
		apb(1'b0, 8'h10, '0);
		chk(40'(rd), 40'h23456b71);
		ask(1'b0);
		stamp(9, 8'h04, SEC + 40'h3e8);
		stamp(16, 8'h04, SEC + 40'h3e8);
	endtask

	task automatic t_clear();
		elir_event_type e;
		apb(1'b1, 8'h00, 32'h00000400);
		fill_raw <= 8'hc8;
		e = '0;
		e.log_cleared = 1'b1;
		pulse(e);
		ask(1'b0);
		chk(fld(3, 4), 40'h0);
		chk(fld(7, 1), 40'hff);
		stamp(9, 8'hff, '0);
		stamp(16, 8'h04, SEC + 40'h3e8);
	endtask

	task automatic t_policy();
		for (int p = 0; p < 3; p++) begin
			apb(1'b1, 8'h04, 32'h007b0a00 | 32'(p));
			ask(1'b0);
			chk(fld(2, 1), 40'(p));
		end
	endtask

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		fill_raw = '0;
		health = '0;
		ev = '0;
		mismatches = 0;
		check_count = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_report();
		t_adjust();
		t_clear();
		t_policy();
		test_done();
	end
endmodule // tb_top
